// ===== design/mlt_pkg.sv
// Shared constants and types for the protocol translator
package mlt_pkg;
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DISC = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INP = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS = 8'h10;
  localparam logic [7:0] FC_RAND_RD = 8'h64;
  localparam logic [7:0] LC_PRI_READ = 8'h01;
  localparam logic [7:0] LC_PRI_WRITE = 8'h02;
  localparam logic [7:0] LC_LP_READ = 8'h03;
  localparam logic [7:0] LC_LP_WRITE = 8'h04;
  localparam logic [7:0] LC_RAND_READ = 8'h05;
  localparam logic [7:0] EX_ILL_FUNC = 8'h01;
  localparam logic [7:0] EX_ILL_ADDR = 8'h02;
  localparam logic [7:0] EX_ILL_VAL = 8'h03;
  localparam logic [7:0] EX_SPAN = 8'h05;
  localparam logic [7:0] EX_PATH = 8'h0A;
  localparam logic [7:0] EX_NO_RESP = 8'h0B;
  localparam logic [7:0] LE_ILL_ADDR = 8'h03;
  localparam logic [7:0] LE_ILL_VAL = 8'h05;
  localparam logic [7:0] LE_ROUTE = 8'h1D;
  localparam logic [7:0] LE_NO_RESP = 8'h11;
  localparam logic [7:0] MAX_LEG_REGS = 8'h80;
  localparam logic [7:0] MAX_MB_READ = 8'h7D;
  localparam logic [7:0] MAX_MB_WRITE = 8'h78;
  localparam logic [7:0] BITS_PER_REG = 8'h10;
  localparam logic [3:0] BIT_SHIFT = 4'h4;
  localparam logic [15:0] COIL_ON = 16'hFF00;
  localparam logic [4:0] COIL_BURST = 5'h0F;
  localparam logic [2:0] ROUTE_MAX = 3'h4;
  localparam logic [15:0] DEF_BAUD = 16'h2580;
  localparam logic [3:0] DEF_DATA_BITS = 4'h8;
  localparam logic [1:0] DEF_STOP_BITS = 2'h1;
  typedef enum logic [1:0] {mlt_modbus, mlt_modbus_host, mlt_legacy,
    paired_network_link_mode} mlt_mode_t;
  typedef enum logic [1:0] {mlt_par_none, mlt_par_even, mlt_par_odd} mlt_parity_t;
  typedef enum logic {mlt_bcc, mlt_crc16} mlt_csum_t;
  typedef enum logic [2:0] {mlt_leg_read, mlt_leg_write, mlt_mb_req, mlt_except,
    mlt_pass} mlt_kind_t;
  typedef struct packed {
    mlt_mode_t mode; logic [7:0] drop; logic [15:0] baud; mlt_parity_t parity;
    logic [3:0] data_bits; logic [1:0] stop_bits; logic four_wire; mlt_csum_t csum;
    logic [7:0] map_read_fc; logic [7:0] map_write_fc;
  } mlt_cfg_t;
  typedef struct packed {
    logic from_legacy; logic [7:0] func; logic [15:0] addr; logic [7:0] count;
    logic [15:0] data; logic masked; logic [15:0] mask; logic [3:0] tag;
    logic route_empty; logic route_other; logic [31:0] route; logic [2:0] route_len;
  } mlt_req_t;
  typedef struct packed {
    mlt_kind_t kind; logic [7:0] func; logic [15:0] addr; logic [7:0] count;
    logic [15:0] data; logic [15:0] mask; logic low_prio; logic [3:0] tag;
    logic [31:0] route; logic [2:0] route_len;
  } mlt_cmd_t;
  typedef struct packed {
    logic [3:0] tag; logic to_modbus; logic err; logic [7:0] code; logic [15:0] data;
  } mlt_rsp_t;
endpackage : mlt_pkg

// ===== design/mlt_translator.sv
// Request translator between register-protocol and legacy-network messages
// Notes on behaviour
// - Holding reads and writes map one-to-one onto legacy registers.
// - Input-register reads map like holding reads.
// - Coil n is register (n-1)/16+1, bit (n-1)%16+1.
// - Legacy bits run 1 to 16, bit 1 the LSB.
// - Discrete inputs map like coils.
// - Each register or bit command becomes a low-priority transfer.
// - Coil writes become bit-masked low-priority writes.
// - Multiple-coil writes spanning registers get exception 5.
// - Legacy reads become holding reads, writes multiple writes.
// - Legacy random read becomes the vendor random-read code.
// - Custom-map mode uses configured function codes.
// - Unmasked writes into coil space force all 16 bits.
// - Legacy carries 128 registers; translated reads 125, writes 120.
// - Errors 2/3, 3/5, 10/29, 11/17 translate both ways.
// - Other error codes pass unchanged.
// - Legacy defaults: 9600, even, 8, 1, four-wire, block check.
// - Port drop ends inbound routes, starts PLC-originated routes.
// - Legacy port is full duplex; PLC is master and slave.
// - Paired ends agree on drop, framing and checksum.
// - A paired-link route holds the pair's drop once.
// - Other-type route entries get translation, not pass-through.
// - Messages with an empty route entry are dropped silently.
`timescale 1ns/1ns
`default_nettype none

module mlt_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } mlt_fifo_state_t;
  mlt_fifo_state_t st;
  mlt_fifo_state_t next_st;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign empty = st.wr == st.rd;
  assign full = (st.wr[AW-1:0] == st.rd[AW-1:0]) && (st.wr[AW] != st.rd[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st.mem[st.rd[AW-1:0]];

  always_comb begin
    next_st = st;
    if (in_valid && !full) begin
      next_st.mem[st.wr[AW-1:0]] = in_data;
      next_st.wr = st.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      next_st.rd = st.rd + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : mlt_fifo

module mlt_translator #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire mlt_pkg::mlt_cfg_t cfg,
  input wire mlt_pkg::mlt_cfg_t peer_cfg,
  output mlt_pkg::mlt_cfg_t default_cfg,
  output logic link_ok,
  input wire logic req_valid,
  output logic req_ready,
  input wire mlt_pkg::mlt_req_t req,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output mlt_pkg::mlt_cmd_t cmd,
  input wire logic rsp_valid,
  input wire mlt_pkg::mlt_rsp_t rsp,
  output logic rsp_out_valid,
  output mlt_pkg::mlt_rsp_t rsp_out,
  output logic discard
);
  typedef struct packed {
    logic busy;
    mlt_pkg::mlt_cmd_t item;
    logic [4:0] left;
    logic [15:0] pending;
    logic rsp_v;
    mlt_pkg::mlt_rsp_t rsp;
    logic discard;
    logic link_ok;
  } mlt_state_t;
  mlt_state_t st;
  mlt_state_t next_st;
  logic push;
  logic fifo_ready;
  logic [$bits(mlt_pkg::mlt_cmd_t)-1:0] fifo_out;

  // Direction bit picks the half of the table
  function automatic logic [7:0] err_map(input logic to_mb, input logic [7:0] c);
    unique case ({to_mb, c})
      {1'b0, mlt_pkg::EX_ILL_ADDR}: err_map = mlt_pkg::LE_ILL_ADDR;
      {1'b0, mlt_pkg::EX_ILL_VAL}: err_map = mlt_pkg::LE_ILL_VAL;
      {1'b0, mlt_pkg::EX_PATH}: err_map = mlt_pkg::LE_ROUTE;
      {1'b0, mlt_pkg::EX_NO_RESP}: err_map = mlt_pkg::LE_NO_RESP;
      {1'b1, mlt_pkg::LE_ILL_ADDR}: err_map = mlt_pkg::EX_ILL_ADDR;
      {1'b1, mlt_pkg::LE_ILL_VAL}: err_map = mlt_pkg::EX_ILL_VAL;
      {1'b1, mlt_pkg::LE_ROUTE}: err_map = mlt_pkg::EX_PATH;
      {1'b1, mlt_pkg::LE_NO_RESP}: err_map = mlt_pkg::EX_NO_RESP;
      default: err_map = c;
    endcase
  endfunction : err_map

  // Coil to legacy register
  function automatic logic [15:0] coil_reg(input logic [15:0] n);
    coil_reg = ((n - 16'h0001) >> mlt_pkg::BIT_SHIFT) + 16'h0001;
  endfunction : coil_reg

  function automatic logic [3:0] coil_bit(input logic [15:0] n);
    logic [15:0] m;
    m = n - 16'h0001;
    coil_bit = m[3:0];
  endfunction : coil_bit

  function automatic logic [2:0] drop_hits(input logic [31:0] r, input logic [2:0] len,
                                           input logic [7:0] d);
    drop_hits = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < len && r[i*8 +: 8] == d) begin
        drop_hits = drop_hits + 3'h1;
      end
    end
  endfunction : drop_hits

  // Legacy-mode port framing defaults
  assign default_cfg = '{mlt_pkg::mlt_legacy, cfg.drop, mlt_pkg::DEF_BAUD,
    mlt_pkg::mlt_par_even, mlt_pkg::DEF_DATA_BITS, mlt_pkg::DEF_STOP_BITS, 1'b1,
    mlt_pkg::mlt_bcc, cfg.map_read_fc, cfg.map_write_fc};

  // No turn-taking between directions
  assign req_ready = !st.busy;
  assign push = st.busy;
  assign link_ok = st.link_ok;
  assign rsp_out_valid = st.rsp_v;
  assign rsp_out = st.rsp;
  assign discard = st.discard;
  assign cmd = mlt_pkg::mlt_cmd_t'(fifo_out);

  always_comb begin
    mlt_pkg::mlt_cmd_t t;
    logic [15:0] last;
    logic [15:0] pset;
    logic [15:0] pclr;
    logic [31:0] w;
    logic [7:0] fc;
    logic rd;
    logic wr;
    t = '0;
    last = '0;
    pset = '0;
    pclr = '0;
    w = '0;
    fc = '0;
    rd = 1'b0;
    wr = 1'b0;
    next_st = st;
    next_st.discard = 1'b0;
    next_st.rsp_v = 1'b0;
    next_st.link_ok = peer_cfg.mode == mlt_pkg::paired_network_link_mode
      && cfg.mode == mlt_pkg::paired_network_link_mode && peer_cfg.drop == cfg.drop
      && peer_cfg.baud == cfg.baud && peer_cfg.parity == cfg.parity
      && peer_cfg.data_bits == cfg.data_bits && peer_cfg.stop_bits == cfg.stop_bits
      && peer_cfg.csum == cfg.csum;
    // Coil burst walks address and data bit by bit
    if (push && fifo_ready) begin
      if (st.left == 5'h00) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.left = st.left - 5'h01;
        next_st.item.addr = st.item.addr + 16'h0001;
        next_st.item.mask = {1'b0, st.item.mask[15:1]};
        next_st.item.data = st.item.mask[1] ? mlt_pkg::COIL_ON : 16'h0000;
      end
    end
    if (req_valid && !st.busy) begin
      t.kind = mlt_pkg::mlt_pass;
      t.func = req.func;
      t.addr = req.addr;
      t.count = req.count;
      t.data = req.data;
      t.mask = req.mask;
      t.tag = req.tag;
      t.route = req.route;
      t.route_len = req.route_len;
      last = req.addr + {8'h00, req.count} - 16'h0001;
      if (req.route_empty) begin
        next_st.discard = 1'b1;
      end else if (!req.route_other) begin
        next_st.busy = 1'b1;
        next_st.left = 5'h00;
        next_st.item = t;
      end else begin
        next_st.busy = 1'b1;
        next_st.left = 5'h00;
        if (cfg.mode == mlt_pkg::paired_network_link_mode
            && drop_hits(req.route, req.route_len, cfg.drop) != 3'h1) begin
          t.kind = mlt_pkg::mlt_except;
          t.func = req.from_legacy ? mlt_pkg::LE_ROUTE : mlt_pkg::EX_PATH;
        end else if (!req.from_legacy) begin
          t.low_prio = 1'b1;
          if (req.route_len < mlt_pkg::ROUTE_MAX) begin
            t.route[req.route_len*8 +: 8] = cfg.drop;
            t.route_len = req.route_len + 3'h1;
          end
          t.kind = mlt_pkg::mlt_leg_read;
          unique case (req.func)
            mlt_pkg::FC_RD_HOLD, mlt_pkg::FC_RD_INP: begin
              if (req.count == 8'h00 || req.count > mlt_pkg::MAX_MB_READ) begin
                t.kind = mlt_pkg::mlt_except;
                t.func = mlt_pkg::EX_ILL_VAL;
              end
            end
            mlt_pkg::FC_WR_REG: begin
              t.kind = mlt_pkg::mlt_leg_write;
              t.count = 8'h01;
            end
            mlt_pkg::FC_WR_REGS: begin
              t.kind = mlt_pkg::mlt_leg_write;
              if (req.count == 8'h00 || req.count > mlt_pkg::MAX_MB_WRITE) begin
                t.kind = mlt_pkg::mlt_except;
                t.func = mlt_pkg::EX_ILL_VAL;
              end
            end
            mlt_pkg::FC_RD_COIL, mlt_pkg::FC_RD_DISC: begin
              t.addr = coil_reg(req.addr);
              t.count = 8'(coil_reg(last) - coil_reg(req.addr) + 16'h0001);
              if (req.count == 8'h00) begin
                t.kind = mlt_pkg::mlt_except;
                t.func = mlt_pkg::EX_ILL_VAL;
              end
            end
            mlt_pkg::FC_WR_COIL: begin
              t.kind = mlt_pkg::mlt_leg_write;
              t.addr = coil_reg(req.addr);
              t.count = 8'h01;
              t.mask = 16'h0001 << coil_bit(req.addr);
              t.data = (req.data == mlt_pkg::COIL_ON) ? t.mask : 16'h0000;
            end
            mlt_pkg::FC_WR_COILS: begin
              t.kind = mlt_pkg::mlt_leg_write;
              t.addr = coil_reg(req.addr);
              t.count = 8'h01;
              w = ((32'h1 << req.count) - 32'h1) << coil_bit(req.addr);
              t.mask = w[15:0];
              w = {16'h0000, req.data} << coil_bit(req.addr);
              t.data = w[15:0] & t.mask;
              if (req.count == 8'h00) begin
                t.kind = mlt_pkg::mlt_except;
                t.func = mlt_pkg::EX_ILL_VAL;
              end else if (coil_reg(last) != coil_reg(req.addr)) begin
                t.kind = mlt_pkg::mlt_except;
                t.func = mlt_pkg::EX_SPAN;
              end
            end
            default: begin
              t.kind = mlt_pkg::mlt_except;
              t.func = mlt_pkg::EX_ILL_FUNC;
            end
          endcase
        end else begin
          t.kind = mlt_pkg::mlt_mb_req;
          t.route = {req.route[23:0], cfg.drop};
          t.route_len = (req.route_len < mlt_pkg::ROUTE_MAX) ?
            req.route_len + 3'h1 : mlt_pkg::ROUTE_MAX;
          rd = req.func == mlt_pkg::LC_PRI_READ || req.func == mlt_pkg::LC_LP_READ;
          wr = req.func == mlt_pkg::LC_PRI_WRITE || req.func == mlt_pkg::LC_LP_WRITE;
          fc = rd ? mlt_pkg::FC_RD_HOLD : mlt_pkg::FC_WR_REGS;
          if (cfg.mode == mlt_pkg::mlt_modbus_host) begin
            fc = rd ? cfg.map_read_fc : cfg.map_write_fc;
          end
          t.func = fc;
          if (fc == mlt_pkg::FC_RD_COIL || fc == mlt_pkg::FC_RD_DISC
              || fc == mlt_pkg::FC_WR_COIL || fc == mlt_pkg::FC_WR_COILS) begin
            t.addr = 16'((req.addr - 16'h0001) << mlt_pkg::BIT_SHIFT) + 16'h0001;
            t.count = rd ? 8'(req.count << mlt_pkg::BIT_SHIFT) : mlt_pkg::BITS_PER_REG;
          end
          if (wr && fc == mlt_pkg::FC_WR_COILS) begin
            t.mask = req.masked ? req.mask : 16'hFFFF;
          end
          if (wr && fc == mlt_pkg::FC_WR_COIL) begin
            // Sixteen writes leave the FIFO one after another
            t.count = 8'h01;
            t.mask = req.data;
            t.data = req.data[0] ? mlt_pkg::COIL_ON : 16'h0000;
            next_st.left = mlt_pkg::COIL_BURST;
          end
          if (req.func == mlt_pkg::LC_RAND_READ) begin
            t.func = mlt_pkg::FC_RAND_RD;
          end else if (!rd && !wr) begin
            t.kind = mlt_pkg::mlt_except;
            t.func = mlt_pkg::LE_ROUTE;
            next_st.left = 5'h00;
          end
          if (req.count > mlt_pkg::MAX_LEG_REGS
              || (rd && req.count > mlt_pkg::MAX_MB_READ)
              || (wr && req.count > mlt_pkg::MAX_MB_WRITE)) begin
            t.kind = mlt_pkg::mlt_except;
            t.func = mlt_pkg::LE_ILL_VAL;
            next_st.left = 5'h00;
          end
        end
        next_st.item = t;
        if (t.kind != mlt_pkg::mlt_except) begin
          pset[req.tag] = 1'b1;
        end
      end
    end
    // Unpaired replies have nowhere to go
    if (rsp_valid && st.pending[rsp.tag]) begin
      pclr[rsp.tag] = 1'b1;
      next_st.rsp_v = 1'b1;
      next_st.rsp = rsp;
      if (rsp.err) begin
        next_st.rsp.code = err_map(rsp.to_modbus,
                                   rsp.code);
      end
    end
    // New request wins over a same-tag clear
    next_st.pending = (st.pending & ~pclr) | pset;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  mlt_fifo #(
    .WIDTH($bits(mlt_pkg::mlt_cmd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(st.item),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(fifo_out)
  );
endmodule : mlt_translator

`default_nettype wire

// ===== testbench/mlt_far_end.sv
// Far-side model: drains commands and, while answer is high, answers all but exception and pass-through ones
`timescale 1ns/1ns
`default_nettype none
module mlt_far_end (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic stall,
  input wire logic answer,
  input wire logic [7:0] err_code,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire mlt_pkg::mlt_cmd_t cmd,
  output logic rsp_valid,
  output mlt_pkg::mlt_rsp_t rsp
);
  mlt_pkg::mlt_cmd_t got[$];
  logic reply;
  assign cmd_ready = !stall;
  assign reply = !reset && cmd_valid && cmd_ready && answer
    && cmd.kind != mlt_pkg::mlt_except && cmd.kind != mlt_pkg::mlt_pass;
  always @(posedge ref_clk) begin
    rsp_valid <= reply;
    if (!reset && cmd_valid && cmd_ready) got.push_back(cmd);
    if (reply) begin
      rsp <= '{cmd.tag, cmd.kind != mlt_pkg::mlt_mb_req, err_code != 8'h00, err_code,
        16'h0000};
    end else begin
      rsp <= reset ? '0 : ~rsp;
    end
  end
endmodule : mlt_far_end
`default_nettype wire

// ===== testbench/mlt_translator_asserts.sv
// Port assertions for the translator
`timescale 1ns/1ns
`default_nettype none
module mlt_translator_asserts (
  input wire logic ref_clk,
  input wire logic reset,
  input wire mlt_pkg::mlt_cfg_t cfg,
  input wire mlt_pkg::mlt_cfg_t peer_cfg,
  input wire mlt_pkg::mlt_cfg_t default_cfg,
  input wire logic link_ok,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire mlt_pkg::mlt_req_t req,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire mlt_pkg::mlt_cmd_t cmd,
  input wire logic rsp_valid,
  input wire mlt_pkg::mlt_rsp_t rsp,
  input wire logic rsp_out_valid,
  input wire mlt_pkg::mlt_rsp_t rsp_out,
  input wire logic discard
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic pair_eq;
  // Mode through stop bits, then checksum
  assign pair_eq = cfg.mode == mlt_pkg::paired_network_link_mode
    && cfg[51:18] == peer_cfg[51:18] && cfg.csum == peer_cfg.csum;
  function automatic logic [7:0] err_xlate(input logic to_mb, input logic [7:0] c);
    logic [31:0] mb = 32'h02_03_0A_0B;
    logic [31:0] lg = 32'h03_05_1D_11;
    err_xlate = c;
    for (int i = 0; i < 32; i += 8) begin
      if (c == (to_mb ? lg[i +: 8] : mb[i +: 8])) err_xlate = to_mb ? mb[i +: 8] : lg[i +: 8];
    end
  endfunction : err_xlate
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_take_idle;
    s_take ##0 !req.route_empty && !cmd_valid;
  endsequence
  sequence s_take_drop;
    s_take ##0 req.route_empty && !cmd_valid;
  endsequence
  a_first_cmd: assert property (s_take_idle |-> ##2 cmd_valid)
    else $error("command late after accept");
  a_cmd_stands: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd))
    else $error("command changed while stalled");
  a_drop_cause: assert property (discard |-> $past(req_valid && req_ready && req.route_empty))
    else $error("discard without empty route");
  a_drop_silent: assert property (s_take_drop |=> !cmd_valid [*2])
    else $error("empty route produced a command");
  a_reply_pair: assert property (
    rsp_out_valid |-> $past(rsp_valid) && rsp_out.tag == $past(rsp.tag))
    else $error("reply without matching input");
  a_err_xlate: assert property (
    rsp_out_valid && rsp_out.err |->
    rsp_out.code == err_xlate($past(rsp.to_modbus), $past(rsp.code)))
    else $error("error code translated wrongly");
  a_default_frame: assert property (default_cfg == mlt_pkg::mlt_cfg_t'{
    mlt_pkg::mlt_legacy, cfg.drop, 16'h2580, mlt_pkg::mlt_par_even, 4'h8, 2'h1, 1'b1,
    mlt_pkg::mlt_bcc, cfg.map_read_fc, cfg.map_write_fc}) else $error("default framing wrong");
  a_link_match: assert property (!$past(reset) |-> link_ok == $past(pair_eq))
    else $error("link status wrong");
  a_low_prio: assert property (
    cmd_valid && (cmd.kind == mlt_pkg::mlt_leg_read || cmd.kind == mlt_pkg::mlt_leg_write)
    |-> cmd.low_prio)
    else $error("register command not low priority");
endmodule : mlt_translator_asserts
bind mlt_translator mlt_translator_asserts u_chk (
  .ref_clk(ref_clk), .reset(reset), .cfg(cfg), .peer_cfg(peer_cfg),
  .default_cfg(default_cfg), .link_ok(link_ok), .req_valid(req_valid),
  .req_ready(req_ready), .req(req), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp), .rsp_out_valid(rsp_out_valid),
  .rsp_out(rsp_out), .discard(discard));
`default_nettype wire

// ===== testbench/mlt_translator_bench.sv
// Self-checking bench for the protocol translator
`timescale 1ns/1ns
`default_nettype none
module mlt_translator_bench;
  localparam mlt_pkg::mlt_kind_t K_RD = mlt_pkg::mlt_leg_read;
  localparam mlt_pkg::mlt_kind_t K_WR = mlt_pkg::mlt_leg_write;
  localparam mlt_pkg::mlt_kind_t K_EX = mlt_pkg::mlt_except;
  localparam mlt_pkg::mlt_kind_t K_MB = mlt_pkg::mlt_mb_req;
  logic ref_clk, reset, req_valid, req_ready, cmd_valid, cmd_ready;
  logic rsp_valid, rsp_out_valid, discard, link_ok, stall, answer;
  logic [7:0] err_code;
  mlt_pkg::mlt_cfg_t cfg, peer_cfg, default_cfg, p;
  mlt_pkg::mlt_req_t req;
  mlt_pkg::mlt_cmd_t cmd, c;
  mlt_pkg::mlt_rsp_t rsp, rsp_out;
  mlt_pkg::mlt_rsp_t rq[$];
  int n_errors = 0;
  int check_count = 0;
  int n_drop = 0;
  int seen = 0;
  mlt_translator #(.FIFO_DEPTH(8)) dut (.ref_clk(ref_clk), .reset(reset), .cfg(cfg),
    .peer_cfg(peer_cfg), .default_cfg(default_cfg), .link_ok(link_ok),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .rsp_valid(rsp_valid), .rsp(rsp),
    .rsp_out_valid(rsp_out_valid), .rsp_out(rsp_out), .discard(discard));
  mlt_far_end far (.ref_clk(ref_clk), .reset(reset), .stall(stall), .answer(answer),
    .err_code(err_code), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rsp_out_valid === 1'b1) rq.push_back(rsp_out);
    if (discard === 1'b1) n_drop++;
  end
  function automatic mlt_pkg::mlt_cfg_t mk_cfg(input mlt_pkg::mlt_mode_t m,
      input logic [7:0] rf, input logic [7:0] wf);
    return '{m, 8'h65, 16'h2580, mlt_pkg::mlt_par_even, 4'h8, 2'h1, 1'b1, mlt_pkg::mlt_bcc,
      rf, wf};
  endfunction : mk_cfg
  function automatic mlt_pkg::mlt_req_t mk_req(input logic leg, input logic [7:0] fc,
      input logic [15:0] a, input logic [7:0] n, input logic [15:0] d, input logic [3:0] t);
    return '{leg, fc, a, n, d, 1'b0, 16'h0000, t, 1'b0, 1'b1, 32'h0000_0005, 3'h1};
  endfunction : mk_req
  task chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task stop_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  task send(input mlt_pkg::mlt_req_t r);
    int i;
    @(posedge ref_clk);
    req <= r;
    req_valid <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge ref_clk);
      if (req_ready === 1'b1) break;
    end
    req_valid <= 1'b0;
    req <= ~r;
  endtask : send
  task next_cmd;
    int i;
    for (i = 0; i < 200 && far.got.size() <= seen; i++) @(posedge ref_clk);
    chk(far.got.size() > seen, 1);
    c = far.got[seen];
    seen++;
  endtask : next_cmd
  task reg_case(input logic [7:0] fc, input logic [15:0] a, input logic [7:0] n,
      input logic [15:0] d, input mlt_pkg::mlt_kind_t k, input logic [15:0] v,
      input logic [15:0] m);
    send(mk_req(1'b0, fc, a, n, d, 4'h1));
    next_cmd;
    chk(c.kind, k);
    if (k == K_EX) chk(c.func, v);
    else begin
      chk(c.addr, v);
      chk(c.low_prio, 1);
      chk(c.route[15:8], 8'h65);
      if (m != 0) chk(c.mask, m);
    end
  endtask : reg_case
  task leg_case(input logic [7:0] lc, input logic [7:0] n, input mlt_pkg::mlt_kind_t k,
      input logic [7:0] f, input logic [15:0] a);
    send(mk_req(1'b1, lc, 16'h0003, n, 16'h0005, 4'h2));
    next_cmd;
    chk(c.kind, k);
    chk(c.func, f);
    if (k == K_MB) begin
      chk(c.addr, a);
      chk(c.route[7:0], 8'h65);
    end
  endtask : leg_case
  task rsp_chk(input logic [7:0] code, input logic [3:0] t, input logic tm);
    int i;
    next_cmd;
    for (i = 0; i < 50 && rq.size() == 0; i++) @(posedge ref_clk);
    chk(rq.size(), 1);
    chk(rq[0].code, code);
    chk({rq[0].tag, rq[0].to_modbus, rq[0].err}, {t, tm, 1'b1});
    rq.delete();
  endtask : rsp_chk
  task t_cfg;
    p = mk_cfg(mlt_pkg::paired_network_link_mode, 8'h03, 8'h10);
    p.baud = 16'h4B00;
    p.parity = mlt_pkg::mlt_par_odd;
    p.csum = mlt_pkg::mlt_crc16;
    cfg <= p;
    peer_cfg <= p;
    repeat (3) @(posedge ref_clk);
    chk(default_cfg, mk_cfg(mlt_pkg::mlt_legacy, 8'h03, 8'h10));
    chk(link_ok, 1);
    peer_cfg.csum <= mlt_pkg::mlt_bcc;
    repeat (3) @(posedge ref_clk);
    chk(link_ok, 0);
    p.drop = 8'h66;
    peer_cfg <= p;
    repeat (3) @(posedge ref_clk);
    chk(link_ok, 0);
  endtask : t_cfg
  task t_reg;
    cfg <= mk_cfg(mlt_pkg::mlt_modbus, 8'h03, 8'h10);
    reg_case(8'h03, 16'h05DF, 8'h7D, 0, K_RD, 16'h05DF, 0);
    reg_case(8'h04, 16'h0007, 8'h01, 0, K_RD, 16'h0007, 0);
    reg_case(8'h03, 16'h0001, 8'h7E, 0, K_EX, 16'h0003, 0);
    reg_case(8'h10, 16'h0014, 8'h79, 0, K_EX, 16'h0003, 0);
    reg_case(8'h10, 16'h0014, 8'h78, 0, K_WR, 16'h0014, 0);
    reg_case(8'h06, 16'h0014, 8'h01, 16'h1234, K_WR, 16'h0014, 0);
    reg_case(8'h05, 16'h0011, 8'h01, 16'hFF00, K_WR, 16'h0002, 16'h0001);
    reg_case(8'h05, 16'h0010, 8'h01, 16'hFF00, K_WR, 16'h0001, 16'h8000);
    reg_case(8'h0F, 16'h0011, 8'h10, 16'hFFFF, K_WR, 16'h0002, 16'hFFFF);
    reg_case(8'h0F, 16'h000A, 8'h08, 16'h00FF, K_EX, 16'h0005, 0);
    reg_case(8'h02, 16'h0021, 8'h10, 0, K_RD, 16'h0003, 0);
    reg_case(8'h01, 16'h0001, 8'h01, 0, K_RD, 16'h0001, 0);
    cfg <= mk_cfg(mlt_pkg::paired_network_link_mode, 8'h03, 8'h10);
    reg_case(8'h03, 16'h0001, 8'h01, 0, K_EX, 16'h000A, 0);
  endtask : t_reg
  task t_leg;
    int i;
    logic [7:0] wf[3] = '{8'h06, 8'h0F, 8'h10};
    cfg <= mk_cfg(mlt_pkg::mlt_legacy, 8'h03, 8'h10);
    leg_case(8'h01, 8'h7D, K_MB, 8'h03, 16'h0003);
    leg_case(8'h03, 8'h01, K_MB, 8'h03, 16'h0003);
    leg_case(8'h02, 8'h78, K_MB, 8'h10, 16'h0003);
    leg_case(8'h04, 8'h01, K_MB, 8'h10, 16'h0003);
    leg_case(8'h05, 8'h01, K_MB, 8'h64, 16'h0003);
    leg_case(8'h03, 8'h7E, K_EX, 8'h05, 0);
    leg_case(8'h04, 8'h79, K_EX, 8'h05, 0);
    leg_case(8'h01, 8'h81, K_EX, 8'h05, 0);
    reg_case(8'h03, 16'h0009, 8'h02, 0, K_RD, 16'h0009, 0);
    for (i = 1; i <= 4; i++) begin
      cfg <= mk_cfg(mlt_pkg::mlt_modbus_host, 8'(i), wf[i-1]);
      leg_case(8'h03, 8'h01, K_MB, 8'(i), i < 3 ? 16'h0021 : 16'h0003);
      if (i < 4) leg_case(8'h04, 8'h01, K_MB, wf[i-1], i == 2 ? 16'h0021 : 16'h0003);
    end
  endtask : t_leg
  task t_route;
    mlt_pkg::mlt_req_t r;
    r = mk_req(1'b0, 8'h03, 16'h0001, 8'h01, 16'h0000, 4'h4);
    r.route_empty = 1'b1;
    send(r);
    repeat (5) @(posedge ref_clk);
    chk(n_drop, 1);
    chk(far.got.size(), seen);
    r.route_empty = 1'b0;
    r.route_other = 1'b0;
    send(r);
    next_cmd;
    chk({c.kind, c.addr}, {mlt_pkg::mlt_pass, 16'h0001});
  endtask : t_route
  task t_burst;
    int i;
    cfg <= mk_cfg(mlt_pkg::mlt_modbus_host, 8'h03, 8'h05);
    stall <= 1'b1;
    send(mk_req(1'b1, 8'h04, 16'h0002, 8'h01, 16'h8005, 4'h3));
    repeat (30) @(posedge ref_clk);
    chk({req_ready, cmd_valid}, 2'b01);
    stall <= 1'b0;
    for (i = 0; i < 16; i++) begin
      next_cmd;
      chk({c.func, c.addr}, {8'h05, 16'h0011 + 16'(i)});
      chk(c.data, (16'h8005 >> i) & 1 ? 16'hFF00 : 16'h0000);
    end
  endtask : t_burst
  task t_reply;
    int i;
    logic [7:0] lg[5] = '{8'h03, 8'h05, 8'h1D, 8'h11, 8'h07};
    logic [7:0] mb[5] = '{8'h02, 8'h03, 8'h0A, 8'h0B, 8'h07};
    answer <= 1'b1;
    for (i = 0; i < 5; i++) begin
      err_code <= lg[i];
      cfg <= mk_cfg(mlt_pkg::mlt_modbus, 8'h03, 8'h10);
      send(mk_req(1'b0, 8'h03, 16'h0001, 8'h01, 16'h0000, 4'(i)));
      rsp_chk(mb[i], 4'(i), 1'b1);
      err_code <= mb[i];
      cfg <= mk_cfg(mlt_pkg::mlt_legacy, 8'h03, 8'h10);
      send(mk_req(1'b1, 8'h01, 16'h0001, 8'h01, 16'h0000, 4'(i + 8)));
      rsp_chk(lg[i], 4'(i + 8), 1'b0);
    end
  endtask : t_reply
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    stop_test;
  end
  initial begin
    reset = 1'b1;
    req_valid = 1'b0;
    req = '0;
    stall = 1'b0;
    answer = 1'b0;
    err_code = 8'h00;
    cfg = mk_cfg(mlt_pkg::mlt_modbus, 8'h03, 8'h10);
    peer_cfg = cfg;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_cfg;
    t_reg;
    t_leg;
    t_route;
    t_burst;
    t_reply;
    stop_test;
  end
endmodule : mlt_translator_bench
`default_nettype wire
